// File: swsc_defines.svh
`ifndef SWSC_DEFINES_SVH
`define SWSC_DEFINES_SVH

// Register byte offsets
`define SWSC_OFF_SVC 8'h00
`define SWSC_OFF_CTRL 8'h04
`define SWSC_OFF_STAT 8'h08
`define SWSC_OFF_IDLE 8'h0c
`define SWSC_OFF_WCNT 8'h10

// Service register fields
`define SWSC_SEL_HI 7
`define SWSC_SEL_LO 6
`define SWSC_KEY_HI 5
`define SWSC_KEY_LO 1
`define SWSC_CMEN_BIT 0
`define SWSC_KEY_VAL 5'h0c

// Reset values
`define SWSC_SEL_RST 2'h3
`define SWSC_CMEN_RST 1'b1

// Status register bit positions
`define SWSC_ST_TICK 0
`define SWSC_ST_FAULT 1
`define SWSC_ST_CMERR 2
`define SWSC_ST_FIRST 3

// Timing counts in instruction cycles; SWSC_TC_DIV is clocks per instruction cycle, SWSC_TICK_BIT a bit index
`define SWSC_LOWER_TC 2048
`define SWSC_UPPER_BASE_TC 8192
`define SWSC_REL_TC 16
`define SWSC_TC_DIV 4
`define SWSC_CM_MIN_TC 8
`define SWSC_TICK_BIT 12

`endif

// File: swsc_pkg.sv
package swsc_pkg;

  typedef struct packed {
    logic [1:0] win_sel;
    logic [4:0] key;
    logic cm_en;
  } swsc_svc_t;

  typedef enum logic [1:0] {
    FS_IDLE,
    FS_PULL,
    FS_HOLD,
    FS_RISE
  } swsc_fault_state_t;

endpackage : swsc_pkg

// File: swsc_supervisor.sv
// Summary of operation
// - Service matching key (and, after the first, window and monitor fields) restarts window; mismatch faults.
// - Clock monitor frequency error pulls the shared fault pin low.
// - Monitor error holds until clock recovers; pin released 16 instruction cycles later.
// - Oscillator never starting or staying slow keeps the monitor error continuous.
// - Both detectors are inhibited while reset is asserted.
// - After reset both are enabled with the largest window selected.
// - Window select and monitor enable change only on first service write.
// - Service register reads return zeros in the key field.
// - Supervisory timer is inhibited during halt and idle modes.
// - Clock monitor stays active in halt; halted clock reports a monitor error.
// - RC option with clock delay clear resumes window count after halt.
// - Otherwise window reloads after halt; software waits the lower limit.
// - Idle exit performs an automatic service; software waits the lower limit.
// - First service accepted anywhere within the largest window, even early.
// - Idle tick pending sets on every toggle of idle counter bit 12.
// - Idle counter is not initialised by reset.
// - Service register: window select 7:6, key 5:1, monitor enable bit 0.
// - Window upper limit 8k to 64k cycles by select; lower limit 2048.
// - A service after the first one, earlier than the lower limit, is a fault.
// - Window restarts when fault pin returns high; services ignored meanwhile.
`timescale 1ns/1ns
`include "swsc_defines.svh"

module swsc_supervisor #(
  parameter int TC_DIV = `SWSC_TC_DIV,
  parameter int LOWER_TC = `SWSC_LOWER_TC,
  parameter int UPPER_BASE_TC = `SWSC_UPPER_BASE_TC,
  parameter int CM_MIN_TC = `SWSC_CM_MIN_TC,
  parameter bit RC_OSC_OPTION = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Core power modes
  input wire logic halt_i,
  input wire logic idle_i,
  // Independent slow reference for the clock monitor
  input wire logic cm_ref_i,
  // Open-drain fault pin, port G bit one
  input wire logic port_g_bit_one_i,
  output logic port_g_bit_one_o,
  output logic port_g_bit_one_oe_o,
  // Status
  output logic idle_tick_pending_o
);
  import swsc_pkg::*;
  localparam int WIN_W = 17;
  localparam int DIV_W = 8;
  if (TC_DIV < 1 || TC_DIV > 255 || LOWER_TC < 1 ||
      LOWER_TC >= UPPER_BASE_TC || UPPER_BASE_TC * 8 > 65536 ||
      CM_MIN_TC < 1 || CM_MIN_TC > 65535) begin : g_bad_param
    $error("swsc_supervisor: unsupported parameter values");
  end

  function automatic logic [WIN_W-1:0] upper_limit(input logic [1:0] sel);
    logic [WIN_W-1:0] base;
    base = WIN_W'(UPPER_BASE_TC);
    upper_limit = base << sel;
  endfunction : upper_limit
  // Instruction cycle enable; halt stops the instruction clock
  logic [DIV_W-1:0] div_q;
  logic tc_run;
  logic tc;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
    end else if (div_q == DIV_W'(TC_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tc_run = (div_q == DIV_W'(TC_DIV - 1));
  assign tc = tc_run && !halt_i;
  // Pin synchronisers
  logic pin_s1_q, pin_s2_q, ref_s1_q, ref_s2_q, ref_s3_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= port_g_bit_one_i;
      pin_s2_q <= pin_s1_q;
      ref_s1_q <= cm_ref_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // AHB-Lite address and data phase
  logic ap;
  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic svc_wr, ctrl_wr, stat_wr, idle_wr;

  assign ap = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= '0;
    end else if (hready_i) begin
      dp_wr_q <= ap && hwrite_i;
      dp_addr_q <= haddr_i[7:0];
    end
  end

  assign svc_wr = dp_wr_q && (dp_addr_q == `SWSC_OFF_SVC);
  assign ctrl_wr = dp_wr_q && (dp_addr_q == `SWSC_OFF_CTRL);
  assign stat_wr = dp_wr_q && (dp_addr_q == `SWSC_OFF_STAT);
  assign idle_wr = dp_wr_q && (dp_addr_q == `SWSC_OFF_IDLE);
  // Service register and first-write lock
  swsc_svc_t svc_q;
  logic first_done_q;
  logic clk_dly_q;
  swsc_fault_state_t fs_q;
  logic [WIN_W-1:0] win_q;
  logic svc_take, key_ok, svc_ok, wd_trig;
  assign svc_take = svc_wr && (fs_q == FS_IDLE);
  assign key_ok = hwdata_i[`SWSC_KEY_HI:`SWSC_KEY_LO] == `SWSC_KEY_VAL;
  // Later services must repeat all fields and respect the lower limit
  assign svc_ok = !first_done_q ? key_ok :
    (hwdata_i[7:0] == svc_q) && (win_q >= WIN_W'(LOWER_TC));
  assign wd_trig = (svc_take && !svc_ok) ||
    (fs_q == FS_IDLE && tc && !idle_i &&
     win_q == upper_limit(svc_q.win_sel) - 1'b1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_q.win_sel <= `SWSC_SEL_RST;
      svc_q.key <= `SWSC_KEY_VAL;
      svc_q.cm_en <= `SWSC_CMEN_RST;
      first_done_q <= 1'b0;
    end else if (svc_take && svc_ok && !first_done_q) begin
      svc_q.win_sel <= hwdata_i[`SWSC_SEL_HI:`SWSC_SEL_LO];
      svc_q.cm_en <= hwdata_i[`SWSC_CMEN_BIT];
      first_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_dly_q <= 1'b0;
    end else if (ctrl_wr) begin
      clk_dly_q <= hwdata_i[0];
    end
  end

  // Clock monitor: instruction cycles per reference period
  logic [15:0] cm_cnt_q;
  logic cm_err_q, cm_arm_q;
  logic ref_edge;

  assign ref_edge = ref_s2_q && !ref_s3_q;
  // First period after reset is partial, so it only arms the check
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cm_cnt_q <= '0;
      cm_arm_q <= 1'b0;
      cm_err_q <= 1'b0;
    end else if (ref_edge) begin
      cm_cnt_q <= '0;
      cm_arm_q <= 1'b1;
      // Slow, halted or never-started clock keeps failing each period
      cm_err_q <= cm_arm_q && svc_q.cm_en &&
        (cm_cnt_q < 16'(CM_MIN_TC));
    end else if (tc && cm_cnt_q != 16'hffff) begin
      cm_cnt_q <= cm_cnt_q + 1'b1;
    end
  end

  // Fault pin sequencer
  logic [4:0] rel_q;
  logic oe_q, pin_out_q;
  logic pin_rise;

  assign pin_rise = (fs_q == FS_RISE) && pin_s2_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_q <= FS_IDLE;
      rel_q <= '0;
      oe_q <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      case (fs_q)
        FS_IDLE: begin
          if (wd_trig || cm_err_q) begin
            fs_q <= FS_PULL;
            oe_q <= 1'b1;
          end
        end
        FS_PULL: begin
          rel_q <= '0;
          if (!pin_s2_q) begin
            fs_q <= FS_HOLD;
          end
        end
        FS_HOLD: begin
          if (cm_err_q) begin
            rel_q <= '0;
          end else if (tc && rel_q == 5'(`SWSC_REL_TC - 1)) begin
            fs_q <= FS_RISE;
            oe_q <= 1'b0;
          end else if (tc) begin
            rel_q <= rel_q + 1'b1;
          end
        end
        FS_RISE: begin
          if (cm_err_q) begin
            fs_q <= FS_PULL;
            oe_q <= 1'b1;
          end else if (pin_s2_q) begin
            fs_q <= FS_IDLE;
          end
        end
        default: begin
          fs_q <= FS_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Service window counter
  logic halt_d_q, idle_d_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_d_q <= 1'b0;
      idle_d_q <= 1'b0;
      win_q <= '0;
    end else begin
      halt_d_q <= halt_i;
      idle_d_q <= idle_i;
      if (pin_rise || (svc_take && svc_ok)) begin
        win_q <= '0;
      end else if (idle_d_q && !idle_i) begin
        win_q <= '0;
      end else if (halt_d_q && !halt_i &&
                   !(RC_OSC_OPTION && !clk_dly_q)) begin
        win_q <= '0;
      end else if (fs_q == FS_IDLE && tc && !idle_i) begin
        win_q <= win_q + 1'b1;
      end
    end
  end

  // Idle counter keeps its value through reset
  logic [15:0] idle_cnt_q;
  logic tick_set, tick_q;
  always_ff @(posedge clk_i) begin
    if (idle_wr) begin
      idle_cnt_q <= hwdata_i[15:0];
    end else if (tc) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  assign tick_set = tc && !idle_wr &&
    (idle_cnt_q[`SWSC_TICK_BIT-1:0] == '1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
    end else if (tick_set) begin
      tick_q <= 1'b1; // Set wins over a same-cycle clear
    end else if (stat_wr && hwdata_i[`SWSC_ST_TICK]) begin
      tick_q <= 1'b0;
    end
  end

  // Read path, registered in the address phase
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = '0;
    case (a)
      `SWSC_OFF_SVC: rd_mux = {24'h0, svc_q.win_sel, 5'h00,
                               svc_q.cm_en};
      `SWSC_OFF_CTRL: rd_mux = {31'h0, clk_dly_q};
      `SWSC_OFF_STAT: rd_mux = {28'h0, first_done_q, cm_err_q,
                                fs_q != FS_IDLE, tick_q};
      `SWSC_OFF_IDLE: rd_mux = {16'h0, idle_cnt_q};
      `SWSC_OFF_WCNT: rd_mux = {15'h0, win_q};
      default: rd_mux = '0;
    endcase
  endfunction : rd_mux

  logic [31:0] rdata_q;
  logic rdy_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
      rdata_q <= (ap && !hwrite_i) ? rd_mux(haddr_i[7:0]) : '0;
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = rdy_q;
  assign hresp_o = 1'b0 & rdy_q;
  assign port_g_bit_one_o = pin_out_q;
  assign port_g_bit_one_oe_o = oe_q;
  assign idle_tick_pending_o = tick_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_bad_key;
    svc_take && !key_ok |=> port_g_bit_one_oe_o;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key");
  property p_early;
    svc_take && first_done_q && win_q < WIN_W'(LOWER_TC)
      |=> fs_q == FS_PULL;
  endproperty
  a_early: assert property (p_early) else $error("early svc");
  property p_cm_drive;
    cm_err_q && fs_q == FS_IDLE |=> port_g_bit_one_oe_o;
  endproperty
  a_cm_drive: assert property (p_cm_drive) else $error("cm idle");
  property p_hold;
    fs_q == FS_HOLD && cm_err_q
      |=> port_g_bit_one_oe_o && rel_q == 5'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("released");
  property p_lock;
    first_done_q |=> $stable(svc_q.win_sel) && $stable(svc_q.cm_en);
  endproperty
  a_lock: assert property (p_lock) else $error("unlocked");
  property p_key_hidden;
    ap && !hwrite_i && haddr_i[7:0] == `SWSC_OFF_SVC
      |=> hrdata_o[5:1] == 5'h00 && hrdata_o[7:6] == $past(svc_q.win_sel);
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key");
  property p_idle_hold;
    idle_i && idle_d_q && !pin_rise && !svc_take |=> $stable(win_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle");
  property p_idle_exit;
    idle_d_q && !idle_i |=> win_q == '0;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("exit");
  property p_tick;
    tick_set |=> idle_tick_pending_o;
  endproperty
  a_tick: assert property (p_tick) else $error("tick not set");
  property p_first_free;
    svc_take && !first_done_q && key_ok
      |=> !port_g_bit_one_oe_o && win_q == '0;
  endproperty
  a_first_free: assert property (p_first_free)
    else $error("first service rejected");

endmodule : swsc_supervisor

// File: swsc_pullup_model.sv
`timescale 1ns/1ns
module swsc_pullup_model (
  // Clock and pull-down request
  input wire logic clk_i,
  input wire logic oe_i,
  // Resolved wire and last low pulse length
  output logic pin_o,
  output int low_len_o
);
  int run_q;
  // Open drain: the resistor pulls high whenever nobody pulls low
  assign pin_o = oe_i ? 1'b0 : 1'b1;
  always_ff @(posedge clk_i) begin
    if (!pin_o) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      low_len_o <= run_q;
      run_q <= 0;
    end
  end
endmodule : swsc_pullup_model

// File: service_window_supervisor_clock_monitor_bench.sv
`timescale 1ns/1ns
`include "swsc_defines.svh"
module service_window_supervisor_clock_monitor_bench;
  import swsc_pkg::*;
  localparam int LOW = 16;
  localparam int BASE = 64;
  localparam logic [31:0] GOOD = 32'h59;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic halt = 1'b0;
  logic idle = 1'b0;
  logic cm_ref = 1'b0;
  logic pin;
  logic pin_d;
  logic oe;
  logic tick;
  logic [31:0] rd;
  int low_len;
  int refc = 0;
  int failures = 0;
  int cmp_count = 0;

  initial forever #2 clk = ~clk;
  // Slow reference, well above the minimum count per period
  always @(posedge clk) begin
    refc <= (refc == 15) ? 0 : refc + 1;
    if (refc == 15) cm_ref <= ~cm_ref;
  end

  swsc_supervisor #(.TC_DIV(1), .LOWER_TC(LOW), .UPPER_BASE_TC(BASE),
    .CM_MIN_TC(8), .RC_OSC_OPTION(1'b0)) swsc_supervisor_inst (
    .clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .halt_i(halt),
    .idle_i(idle), .cm_ref_i(cm_ref), .port_g_bit_one_i(pin),
    .port_g_bit_one_o(pin_d), .port_g_bit_one_oe_o(oe),
    .idle_tick_pending_o(tick));

  swsc_pullup_model swsc_pullup_model_inst (.clk_i(clk), .oe_i(oe),
    .pin_o(pin), .low_len_o(low_len));

  task tally_and_finish;
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rng(input logic [31:0] v, input logic [31:0] lo,
           input logic [31:0] hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask : rng

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wait_oe(input logic v, input int n);
    int i;
    i = 0;
    while (oe !== v && i < n) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, oe}, {31'h0, v});
  endtask : wait_oe

  task do_fault(input logic [31:0] d);
    bus(1'b1, `SWSC_OFF_SVC, d);
    wait_oe(1'b1, 4);
    wait_oe(1'b0, 80);
    repeat (2) @(posedge clk);
    rng(low_len, 16, 36);
    repeat (4) @(posedge clk);
    bus(1'b0, `SWSC_OFF_WCNT, 0);
    rng(rd, 0, 8);
  endtask : do_fault

  task t_first;
    bus(1'b0, `SWSC_OFF_SVC, 0);
    chk(rd, 32'hc1);
    bus(1'b1, `SWSC_OFF_IDLE, 32'h0fd0);
    // Early first service must still be accepted
    bus(1'b1, `SWSC_OFF_SVC, GOOD);
    repeat (4) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
    bus(1'b0, `SWSC_OFF_SVC, 0);
    chk(rd, 32'h41);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h8, 32'h8);
  endtask : t_first

  task t_tick;
    bus(1'b1, `SWSC_OFF_STAT, 32'h1);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h1, 32'h0);
    repeat (48) @(posedge clk);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h1, 32'h1);
    chk({31'h0, tick}, 32'h1);
    bus(1'b1, `SWSC_OFF_STAT, 32'h1);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h1, 32'h0);
  endtask : t_tick

  task t_valid_early;
    repeat (20) @(posedge clk);
    bus(1'b1, `SWSC_OFF_SVC, GOOD);
    bus(1'b0, `SWSC_OFF_WCNT, 0);
    rng(rd, 0, 4);
    chk({31'h0, oe}, 32'h0);
    // Second service inside the lower limit
    bus(1'b1, `SWSC_OFF_SVC, GOOD);
    wait_oe(1'b1, 4);
    // Bad write while the pin is low must be ignored
    bus(1'b1, `SWSC_OFF_SVC, 32'h0);
    wait_oe(1'b0, 80);
    repeat (12) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
  endtask : t_valid_early

  task t_mismatch;
    logic [31:0] bad [3];
    bad = '{GOOD ^ 32'h2, 32'h19, 32'h58};
    foreach (bad[i]) begin
      repeat (20) @(posedge clk);
      do_fault(bad[i]);
    end
    bus(1'b0, `SWSC_OFF_SVC, 0);
    chk(rd, 32'h41);
  endtask : t_mismatch

  task t_timeout;
    repeat (20) @(posedge clk);
    bus(1'b1, `SWSC_OFF_SVC, GOOD);
    repeat (BASE * 2 - 8) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
    wait_oe(1'b1, 16);
    wait_oe(1'b0, 80);
  endtask : t_timeout

  task t_halt;
    repeat (4) @(posedge clk);
    halt <= 1'b1;
    wait_oe(1'b1, 80);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h4, 32'h4);
    repeat (60) @(posedge clk);
    chk({31'h0, oe}, 32'h1);
    halt <= 1'b0;
    wait_oe(1'b0, 150);
    // Sequence stays busy until the released pin is seen high
    repeat (4) @(posedge clk);
    bus(1'b0, `SWSC_OFF_STAT, 0);
    chk(rd & 32'h6, 32'h0);
  endtask : t_halt

  task t_idle;
    logic seen;
    seen = 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b1, `SWSC_OFF_SVC, GOOD);
    idle <= 1'b1;
    repeat (BASE * 2 + 40) begin
      @(posedge clk);
      if (oe !== 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
    idle <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, `SWSC_OFF_WCNT, 0);
    rng(rd, 0, 8);
    do_fault(GOOD);
  endtask : t_idle

  task t_reset;
    bus(1'b1, `SWSC_OFF_IDLE, 32'h1234);
    bus(1'b1, `SWSC_OFF_SVC, 32'h0);
    wait_oe(1'b1, 4);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, `SWSC_OFF_IDLE, 0);
    rng(rd, 32'h1234, 32'h1240);
    bus(1'b0, `SWSC_OFF_SVC, 0);
    chk(rd, 32'hc1);
    repeat (8) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
  endtask : t_reset

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_first;
    t_tick;
    t_valid_early;
    t_mismatch;
    t_timeout;
    t_halt;
    t_idle;
    t_reset;
    tally_and_finish;
  end

  // Whole run is about a thousand cycles; this only cuts a hang
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
endmodule : service_window_supervisor_clock_monitor_bench
